//--- hdl/port_route_pkg.sv
package port_route_pkg;

	// register port geometry
	localparam int          ADDR_W         = 5;
	localparam int          DATA_W         = 8;

	// configuration region, printed offsets
	localparam logic [4:0]  CLK_OUT_ADDR   = 5'h04;
	localparam logic [4:0]  ROUTE_ADDR     = 5'h06;
	localparam logic [4:0]  SLEW_ADDR      = 5'h07;

	// virtual port region: base plus printed offset
	localparam logic [4:0]  VPORT_BASE     = 5'h10;
	localparam logic [4:0]  VP_DIR_OFS     = 5'h00;
	localparam logic [4:0]  VP_OUT_OFS     = 5'h01;
	localparam logic [4:0]  VP_IN_OFS      = 5'h02;
	localparam logic [4:0]  VP_FLAGS_OFS   = 5'h03;

	// reset values
	localparam logic [7:0]  CLK_OUT_RST    = 8'h00;
	localparam logic [7:0]  ROUTE_RST      = 8'h00;
	localparam logic [7:0]  SLEW_RST       = 8'h00;
	localparam logic [7:0]  VPORT_RST      = 8'h00;

	// clock_output_control fields
	localparam int          ALT_BIT        = 7;
	localparam int          RTC_LSB        = 5;
	localparam int          SEL_LSB        = 2;
	localparam int          CPORT_LSB      = 0;
	localparam logic [7:0]  CLK_OUT_MASK   = 8'hEF;

	// comparator_event_route fields
	localparam int          AC_LSB         = 6;
	localparam int          EV_LSB         = 4;
	localparam int          ASYNC_BIT      = 3;
	localparam int          CH_LSB         = 0;

	// slew_limit_control fields
	localparam int          SLEW_R_BIT     = 7;
	localparam int          SLEW_D_BIT     = 3;
	localparam int          SLEW_C_BIT     = 2;
	localparam int          SLEW_A_BIT     = 0;
	localparam logic [7:0]  SLEW_MASK      = 8'h8D;

	// real port indices
	localparam int          NUM_PORTS      = 6;
	localparam logic [2:0]  PORT_A         = 3'h0;
	localparam logic [2:0]  PORT_C         = 3'h2;
	localparam logic [2:0]  PORT_D         = 3'h3;
	localparam logic [2:0]  PORT_E         = 3'h4;
	localparam logic [2:0]  PORT_R         = 3'h5;

	// pin positions
	localparam logic [2:0]  CLK_EVT_PIN    = 3'h7;
	localparam logic [2:0]  CLK_EVT_ALT    = 3'h4;
	localparam logic [2:0]  RTC_CD_PIN     = 3'h6;
	localparam logic [2:0]  R_PIN          = 3'h0;
	localparam logic [2:0]  AC0_PIN        = 3'h6;
	localparam logic [2:0]  AC1_PIN        = 3'h7;

	// two-bit route codes
	localparam logic [1:0]  CODE_0         = 2'h0;
	localparam logic [1:0]  CODE_1         = 2'h1;
	localparam logic [1:0]  CODE_2         = 2'h2;
	localparam logic [1:0]  CODE_3         = 2'h3;

endpackage

//--- hdl/port_signal_output_routing.sv
// Contract
// - alternate bit moves clock and event output from pin 7 to pin 4.
// - rtc route 00 off, 01 C6, 10 D6, 11 R0.
// - clock choice 00 single, 01 double, 10 quad, 11 reserved (low).
// - clock port 00 off, 01 C, 10 D, 11 E.
// - routed clock uses pin 7 unless the alternate bit moves it.
// - clock wins over event on the same pin.
// - clock reaches the pin only while that pin is an output.
// - comparator port 00 A, 01 C, 10 D, 11 R.
// - each comparator output is enabled by the comparator unit and reaches the pin only while that pin is an output.
// - event port 00 off, 01 C, 10 D, 11 R.
// - event on pin 7 for C and D, pin 0 for R.
// - event reaches the pin only while that pin is an output.
// - async enable switches the event pin to the asynchronous path.
// - three-bit channel choice picks one of eight event channels.
// - slew bits 7 R, 3 D, 2 C, 0 A drive per-port slew outputs.
// - reserved slew bits read zero; software writes zero.
// - virtual direction access equals mapped real port direction access.
// - virtual output access equals mapped real port output access.
// - routing, slew and virtual port registers reset to zero.
// - virtual input register returns the mapped port pin inputs.
// - virtual flags alias mapped port flags, write one to clear.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module port_signal_output_routing
(
	// clock and reset
	input  wire logic                                               clock,
	input  wire logic                                               reset_n,
	// register port
	input  wire logic [port_route_pkg::ADDR_W-1:0]                  reg_addr,
	input  wire logic [7:0]                                         reg_wdata,
	input  wire logic                                               reg_wr,
	input  wire logic                                               reg_rd,
	output logic      [7:0]                                         reg_rdata,
	// virtual port mapping and real port flags
	input  wire logic [2:0]                                         vport_map,
	input  wire logic [port_route_pkg::NUM_PORTS-1:0][7:0]          pin_irq_flags,
	output logic      [7:0]                                         flag_clear,
	output logic      [2:0]                                         flag_clear_port,
	// internal signal sources
	input  wire logic                                               per_clock_single,
	input  wire logic                                               per_clock_double,
	input  wire logic                                               per_clock_quad,
	input  wire logic                                               rtc_clock,
	input  wire logic [7:0]                                         evt_sync,
	input  wire logic [7:0]                                         evt_async,
	input  wire logic [1:0]                                         ac_out,
	input  wire logic [1:0]                                         ac_out_en,
	// pads
	input  wire logic [port_route_pkg::NUM_PORTS-1:0][7:0]          pin_in,
	output logic      [port_route_pkg::NUM_PORTS-1:0][7:0]          pin_out,
	output logic      [port_route_pkg::NUM_PORTS-1:0][7:0]          pin_oe,
	output logic                                                    slew_limit_port_a,
	output logic                                                    slew_limit_port_c,
	output logic                                                    slew_limit_port_d,
	output logic                                                    slew_limit_port_r
);

	localparam int NP = port_route_pkg::NUM_PORTS;

	logic [7:0]         clk_ctrl_q;
	logic [7:0]         route_q;
	logic [7:0]         slew_q;
	logic [NP-1:0][7:0] dir_q;
	logic [NP-1:0][7:0] out_q;
	logic [7:0]         rdata_q;
	logic [7:0]         clr_q;
	logic [2:0]         clr_port_q;
	logic [NP-1:0][7:0] pin_out_q;
	logic [NP-1:0][7:0] pin_oe_q;

	logic [NP-1:0][7:0] ovr_en;
	logic [NP-1:0][7:0] ovr_val;
	logic               map_ok;

	logic               wr_clk;
	logic               wr_route;
	logic               wr_slew;
	logic               wr_vdir;
	logic               wr_vout;
	logic               wr_vflags;

	logic [1:0]         rtc_code;
	logic [1:0]         sel_code;
	logic [1:0]         cport_code;
	logic [1:0]         ac_code;
	logic [1:0]         ev_code;
	logic [2:0]         ce_pin;
	logic               per_clk;
	logic               evt_bit;

	// register decode
	function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
		return a == target;
	endfunction

	// virtual port registers sit at a fixed base plus their offset
	function automatic logic [4:0] vreg(input logic [4:0] ofs);
		return port_route_pkg::VPORT_BASE | ofs;
	endfunction

	assign map_ok    = vport_map < 3'(NP);

	// write decode; an unmapped virtual port drops the write instead of hitting a wrong port
	always_comb
	begin
		wr_clk    = 1'b0;
		wr_route  = 1'b0;
		wr_slew   = 1'b0;
		wr_vdir   = 1'b0;
		wr_vout   = 1'b0;
		wr_vflags = 1'b0;
		if (reg_wr)
		begin
			if (hit(reg_addr, port_route_pkg::CLK_OUT_ADDR))
				wr_clk = 1'b1;
			else if (hit(reg_addr, port_route_pkg::ROUTE_ADDR))
				wr_route = 1'b1;
			else if (hit(reg_addr, port_route_pkg::SLEW_ADDR))
				wr_slew = 1'b1;
			else if (map_ok)
			begin
				if (hit(reg_addr, vreg(port_route_pkg::VP_DIR_OFS)))
					wr_vdir = 1'b1;
				else if (hit(reg_addr, vreg(port_route_pkg::VP_OUT_OFS)))
					wr_vout = 1'b1;
				else if (hit(reg_addr, vreg(port_route_pkg::VP_FLAGS_OFS)))
					wr_vflags = 1'b1;
			end
		end
	end

	assign rtc_code   = clk_ctrl_q[port_route_pkg::RTC_LSB +: 2];
	assign sel_code   = clk_ctrl_q[port_route_pkg::SEL_LSB +: 2];
	assign cport_code = clk_ctrl_q[port_route_pkg::CPORT_LSB +: 2];
	assign ac_code    = route_q[port_route_pkg::AC_LSB +: 2];
	assign ev_code    = route_q[port_route_pkg::EV_LSB +: 2];

	// configuration registers
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			clk_ctrl_q <= port_route_pkg::CLK_OUT_RST;
			route_q    <= port_route_pkg::ROUTE_RST;
			slew_q     <= port_route_pkg::SLEW_RST;
		end
		else
		begin
			if (wr_clk)
				clk_ctrl_q <= reg_wdata & port_route_pkg::CLK_OUT_MASK;
			if (wr_route)
				route_q <= reg_wdata;
			if (wr_slew)
				slew_q <= reg_wdata & port_route_pkg::SLEW_MASK;
		end
	end

	// real port direction and output value, reached through the virtual alias
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			// ports never mapped clear too, so their pads start as inputs
			for (int p = 0; p < NP; p++)
			begin
				dir_q[p] <= port_route_pkg::VPORT_RST;
				out_q[p] <= port_route_pkg::VPORT_RST;
			end
		end
		else
		begin
			if (wr_vdir)
				dir_q[vport_map] <= reg_wdata;
			if (wr_vout)
				out_q[vport_map] <= reg_wdata;
		end
	end

	// flag clear is a one-cycle pulse; the port owning the flags lets a set win
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			clr_q      <= 8'h00;
			clr_port_q <= 3'h0;
		end
		else
		begin
			clr_q      <= wr_vflags ? reg_wdata : 8'h00;
			clr_port_q <= vport_map;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			rdata_q <= 8'h00;
		else if (!reg_rd)
			rdata_q <= 8'h00;
		else if (hit(reg_addr, port_route_pkg::CLK_OUT_ADDR))
			rdata_q <= clk_ctrl_q;
		else if (hit(reg_addr, port_route_pkg::ROUTE_ADDR))
			rdata_q <= route_q;
		else if (hit(reg_addr, port_route_pkg::SLEW_ADDR))
			rdata_q <= slew_q;
		else if (!map_ok)
			rdata_q <= 8'h00;
		else if (hit(reg_addr, vreg(port_route_pkg::VP_DIR_OFS)))
			rdata_q <= dir_q[vport_map];
		else if (hit(reg_addr, vreg(port_route_pkg::VP_OUT_OFS)))
			rdata_q <= out_q[vport_map];
		else if (hit(reg_addr, vreg(port_route_pkg::VP_IN_OFS)))
			rdata_q <= pin_in[vport_map];
		else if (hit(reg_addr, vreg(port_route_pkg::VP_FLAGS_OFS)))
			rdata_q <= pin_irq_flags[vport_map];
		else
			rdata_q <= 8'h00;
	end

	// source selection
	always_comb
	begin
		case (sel_code)
			port_route_pkg::CODE_0: per_clk = per_clock_single;
			port_route_pkg::CODE_1: per_clk = per_clock_double;
			port_route_pkg::CODE_2: per_clk = per_clock_quad;
			default:                per_clk = 1'b0;
		endcase
		if (route_q[port_route_pkg::ASYNC_BIT])
			evt_bit = evt_async[route_q[port_route_pkg::CH_LSB +: 3]];
		else
			evt_bit = evt_sync[route_q[port_route_pkg::CH_LSB +: 3]];
		ce_pin = clk_ctrl_q[port_route_pkg::ALT_BIT] ? port_route_pkg::CLK_EVT_ALT
			: port_route_pkg::CLK_EVT_PIN;
	end

	// overrides, written lowest priority first so later ones win
	always_comb
	begin
		ovr_en  = '0;
		ovr_val = '0;
		// comparator outputs; port chosen here, enable from the comparator
		for (int i = 0; i < 2; i++)
		begin
			logic [2:0] ap;
			logic [2:0] an;
			ap = port_route_pkg::PORT_A;
			an = (i == 0) ? port_route_pkg::AC0_PIN : port_route_pkg::AC1_PIN;
			case (ac_code)
				port_route_pkg::CODE_0: ap = port_route_pkg::PORT_A;
				port_route_pkg::CODE_1: ap = port_route_pkg::PORT_C;
				port_route_pkg::CODE_2: ap = port_route_pkg::PORT_D;
				default:                ap = port_route_pkg::PORT_R;
			endcase
			if (ac_out_en[i])
			begin
				ovr_en[ap][an]  = 1'b1;
				ovr_val[ap][an] = ac_out[i];
			end
		end
		// rtc clock; code 10 means port D, 11 port R
		case (rtc_code)
			port_route_pkg::CODE_1:
			begin
				ovr_en[port_route_pkg::PORT_C][port_route_pkg::RTC_CD_PIN]  = 1'b1;
				ovr_val[port_route_pkg::PORT_C][port_route_pkg::RTC_CD_PIN] = rtc_clock;
			end
			port_route_pkg::CODE_2:
			begin
				ovr_en[port_route_pkg::PORT_D][port_route_pkg::RTC_CD_PIN]  = 1'b1;
				ovr_val[port_route_pkg::PORT_D][port_route_pkg::RTC_CD_PIN] = rtc_clock;
			end
			port_route_pkg::CODE_3:
			begin
				ovr_en[port_route_pkg::PORT_R][port_route_pkg::R_PIN]  = 1'b1;
				ovr_val[port_route_pkg::PORT_R][port_route_pkg::R_PIN] = rtc_clock;
			end
			default:
			begin
			end
		endcase
		// event output
		case (ev_code)
			port_route_pkg::CODE_1:
			begin
				ovr_en[port_route_pkg::PORT_C][ce_pin]  = 1'b1;
				ovr_val[port_route_pkg::PORT_C][ce_pin] = evt_bit;
			end
			port_route_pkg::CODE_2:
			begin
				ovr_en[port_route_pkg::PORT_D][ce_pin]  = 1'b1;
				ovr_val[port_route_pkg::PORT_D][ce_pin] = evt_bit;
			end
			port_route_pkg::CODE_3:
			begin
				ovr_en[port_route_pkg::PORT_R][port_route_pkg::R_PIN]  = 1'b1;
				ovr_val[port_route_pkg::PORT_R][port_route_pkg::R_PIN] = evt_bit;
			end
			default:
			begin
			end
		endcase
		// peripheral clock last, so it wins a shared pin
		case (cport_code)
			port_route_pkg::CODE_1:
			begin
				ovr_en[port_route_pkg::PORT_C][ce_pin]  = 1'b1;
				ovr_val[port_route_pkg::PORT_C][ce_pin] = per_clk;
			end
			port_route_pkg::CODE_2:
			begin
				ovr_en[port_route_pkg::PORT_D][ce_pin]  = 1'b1;
				ovr_val[port_route_pkg::PORT_D][ce_pin] = per_clk;
			end
			port_route_pkg::CODE_3:
			begin
				ovr_en[port_route_pkg::PORT_E][ce_pin]  = 1'b1;
				ovr_val[port_route_pkg::PORT_E][ce_pin] = per_clk;
			end
			default:
			begin
			end
		endcase
	end

	// pad drive is registered: routed signals reach the pad one cycle late,
	// so a routed clock is a sampled copy, not a glitch-free clock tree path
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			pin_out_q <= '0;
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				for (int b = 0; b < 8; b++)
				begin
					if (dir_q[p][b] && ovr_en[p][b])
						pin_out_q[p][b] <= ovr_val[p][b];
					else
						pin_out_q[p][b] <= out_q[p][b];
				end
			end
		end
	end

	// enables are registered too, so each pad's drive and value change in the same cycle
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			pin_oe_q <= '0;
		else
			pin_oe_q <= dir_q;
	end

	assign reg_rdata         = rdata_q;
	assign flag_clear        = clr_q;
	assign flag_clear_port   = clr_port_q;
	assign pin_out           = pin_out_q;
	assign pin_oe            = pin_oe_q;
	assign slew_limit_port_a = slew_q[port_route_pkg::SLEW_A_BIT];
	assign slew_limit_port_c = slew_q[port_route_pkg::SLEW_C_BIT];
	assign slew_limit_port_d = slew_q[port_route_pkg::SLEW_D_BIT];
	assign slew_limit_port_r = slew_q[port_route_pkg::SLEW_R_BIT];

endmodule // port_signal_output_routing

//--- verification/port_route_sva.sv
`timescale 1ns/1ps
module port_route_sva
(
	// clock and reset
	input wire logic                                        clock,
	input wire logic                                        reset_n,
	// register port
	input wire logic [port_route_pkg::ADDR_W-1:0]           reg_addr,
	input wire logic [7:0]                                  reg_wdata,
	input wire logic                                        reg_wr,
	input wire logic                                        reg_rd,
	input wire logic [7:0]                                  reg_rdata,
	// virtual port and flags
	input wire logic [2:0]                                  vport_map,
	input wire logic [port_route_pkg::NUM_PORTS-1:0][7:0]   pin_irq_flags,
	input wire logic [7:0]                                  flag_clear,
	input wire logic [2:0]                                  flag_clear_port,
	// pads
	input wire logic [port_route_pkg::NUM_PORTS-1:0][7:0]   pin_in,
	input wire logic [port_route_pkg::NUM_PORTS-1:0][7:0]   pin_oe,
	input wire logic                                        slew_limit_port_a,
	input wire logic                                        slew_limit_port_c,
	input wire logic                                        slew_limit_port_d,
	input wire logic                                        slew_limit_port_r
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_read: assert property (reg_rd && (reg_addr == 5'h05 ||
		(reg_addr[4] && vport_map > 3'h5)) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_dir_write: assert property (reg_wr && reg_addr == 5'h10 && vport_map < 3'h6 |->
		##2 pin_oe[$past(vport_map, 2)] == $past(reg_wdata, 2))
		else $error("direction write not seen on output enables");
	a_in_read: assert property (reg_rd && reg_addr == 5'h12 && vport_map < 3'h6 |=>
		reg_rdata == $past(pin_in[vport_map]))
		else $error("input read mismatch");
	a_flags_read: assert property (reg_rd && reg_addr == 5'h13 && vport_map < 3'h6 |=>
		reg_rdata == $past(pin_irq_flags[vport_map]))
		else $error("flag read mismatch");
	a_flag_write: assert property (reg_wr && reg_addr == 5'h13 && vport_map < 3'h6 |=>
		flag_clear == $past(reg_wdata) && flag_clear_port == $past(vport_map))
		else $error("flag clear pulse mismatch");
	a_flag_cause: assert property (flag_clear != 8'h00 |->
		$past(reg_wr && reg_addr == 5'h13 && vport_map < 3'h6))
		else $error("flag clear without a write");
	a_slew_write: assert property (reg_wr && reg_addr == 5'h07 |=>
		{slew_limit_port_r, slew_limit_port_d, slew_limit_port_c, slew_limit_port_a} ==
		{$past(reg_wdata[7]), $past(reg_wdata[3]), $past(reg_wdata[2]), $past(reg_wdata[0])})
		else $error("slew outputs mismatch");
	a_slew_hold: assert property (!(reg_wr && reg_addr == 5'h07) |=>
		$stable({slew_limit_port_r, slew_limit_port_d, slew_limit_port_c, slew_limit_port_a}))
		else $error("slew outputs moved without a write");

	c_flag_clear: cover property (flag_clear != 8'h00);
	c_in_read: cover property (reg_rd && reg_addr == 5'h12);
	c_slew_r: cover property (slew_limit_port_r);
endmodule // port_route_sva

bind port_signal_output_routing port_route_sva u_sva (.clock(clock), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .vport_map(vport_map), .pin_irq_flags(pin_irq_flags),
	.flag_clear(flag_clear), .flag_clear_port(flag_clear_port), .pin_in(pin_in),
	.pin_oe(pin_oe), .slew_limit_port_a(slew_limit_port_a),
	.slew_limit_port_c(slew_limit_port_c), .slew_limit_port_d(slew_limit_port_d),
	.slew_limit_port_r(slew_limit_port_r));

//--- verification/pad_model.sv
`timescale 1ns/1ps
module pad_model
(
	// clock and reset
	input wire logic                clock,
	input wire logic                reset_n,
	// pad side of the block
	input wire logic [5:0][7:0]     pin_out,
	input wire logic [5:0][7:0]     pin_oe,
	input wire logic [7:0]          flag_clear,
	input wire logic [2:0]          flag_clear_port,
	// outside world
	input wire logic [5:0][7:0]     ext_level,
	input wire logic [5:0][7:0]     flag_set,
	output logic     [5:0][7:0]     pin_in,
	output logic     [5:0][7:0]     pin_irq_flags
);
	// a driven pin reads back its own level, an input pin the outside level
	always_comb
		pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);

	// a new flag wins over a clear in the same cycle
	always_ff @(posedge clock)
	begin
		for (int p = 0; p < 6; p++)
			pin_irq_flags[p] <= !reset_n ? 8'h00 : (pin_irq_flags[p] &
				~(flag_clear_port == 3'(p) ? flag_clear : 8'h00)) | flag_set[p];
	end
endmodule // pad_model

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
	logic               clock = 1'b0;
	logic               reset_n = 1'b0;
	logic [4:0]         reg_addr = 5'h00;
	logic [7:0]         reg_wdata = 8'h00;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [2:0]         vport_map = 3'h0;
	logic               clk1 = 1'b0, clk2 = 1'b0, clk4 = 1'b0, rtc = 1'b0;
	logic [7:0]         evt_s = 8'h00, evt_a = 8'h00;
	logic [1:0]         ac = 2'h0, ac_en = 2'h0;
	logic [5:0][7:0]    ext_level = {6{8'h3C}}, flag_set = '0;
	logic [5:0][7:0]    pin_irq_flags, pin_in, pin_out, pin_oe;
	logic [7:0]         reg_rdata, flag_clear;
	logic [2:0]         flag_clear_port;
	logic [3:0]         slew;
	int                 failures = 0, checks = 0;
	int                 acp[4] = '{0, 2, 3, 5};

	always #2.5 clock = ~clock;

	port_signal_output_routing DUT (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.vport_map(vport_map), .pin_irq_flags(pin_irq_flags), .flag_clear(flag_clear),
		.flag_clear_port(flag_clear_port), .per_clock_single(clk1), .per_clock_double(clk2),
		.per_clock_quad(clk4), .rtc_clock(rtc), .evt_sync(evt_s), .evt_async(evt_a),
		.ac_out(ac), .ac_out_en(ac_en), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.slew_limit_port_a(slew[0]), .slew_limit_port_c(slew[1]),
		.slew_limit_port_d(slew[2]), .slew_limit_port_r(slew[3]));

	pad_model pads (.clock(clock), .reset_n(reset_n), .pin_out(pin_out), .pin_oe(pin_oe),
		.flag_clear(flag_clear), .flag_clear_port(flag_clear_port), .ext_level(ext_level),
		.flag_set(flag_set), .pin_in(pin_in), .pin_irq_flags(pin_irq_flags));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk("reg_rdata", exp, reg_rdata);
		@(posedge clock);
	endtask

	task automatic cfg(input int m, input logic [7:0] d, input logic [7:0] o);
		vport_map <= 3'(m);
		wr(5'h10, d);
		wr(5'h11, o);
	endtask

	// pins lag their cause by one edge; two edges leave margin
	task automatic pin(input int p, input int b, input logic e);
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("pin_out", {7'h00, e}, {7'h00, pin_out[p][b]});
		@(posedge clock);
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		#50000;
		failures++;
		give_verdict();
	end

	initial
	begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		rd(5'h04, 8'h00);
		rd(5'h06, 8'h00);
		rd(5'h07, 8'h00);
		rd(5'h10, 8'h00);
		rd(5'h11, 8'h00);
		rd(5'h05, 8'h00);
		wr(5'h04, 8'hFF);
		rd(5'h04, 8'hEF);
		wr(5'h07, 8'hFF);
		rd(5'h07, 8'h8D);
		chk("slew", 8'h0F, {4'h0, slew});
		wr(5'h07, 8'h84);
		chk("slew", 8'h0A, {4'h0, slew});
		wr(5'h06, 8'hA5);
		rd(5'h06, 8'hA5);
		wr(5'h04, 8'h00);
		wr(5'h06, 8'h00);
		for (int p = 0; p < 8; p++)
			cfg(p, 8'(p * 17), 8'(~(p * 17)));
		for (int p = 0; p < 8; p++)
		begin
			vport_map <= 3'(p);
			rd(5'h10, p < 6 ? 8'(p * 17) : 8'h00);
			rd(5'h11, p < 6 ? 8'(~(p * 17)) : 8'h00);
			if (p < 6)
			begin
				chk("pin_oe", 8'(p * 17), pin_oe[p]);
				chk("pin_out", 8'(~(p * 17)), pin_out[p]);
			end
		end
		vport_map <= 3'h2;
		rd(5'h12, 8'h1C);
		flag_set[3] <= 8'hFF;
		vport_map <= 3'h3;
		@(posedge clock);
		flag_set <= '0;
		rd(5'h13, 8'hFF);
		wr(5'h13, 8'h0F);
		@(posedge clock);
		rd(5'h13, 8'hF0);
		for (int p = 0; p < 6; p++)
			cfg(p, 8'hFF, 8'h00);
		for (int s = 0; s < 2; s++)
			for (int c = 0; c < 4; c++)
			begin
				{clk4, clk2, clk1} <= s ? 3'b010 : 3'b101;
				wr(5'h04, 8'(c * 4 + 1));
				pin(2, 7, c < 3 && (s ? c == 1 : c != 1));
			end
		{clk4, clk2, clk1} <= 3'b101;
		for (int c = 0; c < 4; c++)
		begin
			wr(5'h04, 8'(c));
			pin(c ? c + 1 : 2, 7, c != 0);
		end
		wr(5'h04, 8'h83);
		pin(4, 4, 1'b1);
		pin(4, 7, 1'b0);
		cfg(4, 8'hEF, 8'h00);
		pin(4, 4, 1'b0);
		wr(5'h04, 8'h00);
		for (int ch = 0; ch < 16; ch++)
		begin
			evt_s <= 8'h01 << ch[2:0];
			evt_a <= ~(8'h01 << ch[2:0]);
			wr(5'h06, 8'(8'h20 + ch));
			pin(3, 7, ch < 8);
		end
		evt_s <= 8'hFF;
		wr(5'h06, 8'h30);
		pin(5, 0, 1'b1);
		wr(5'h04, 8'h80);
		wr(5'h06, 8'h10);
		pin(2, 4, 1'b1);
		{clk4, clk2, clk1} <= 3'b000;
		wr(5'h04, 8'h02);
		wr(5'h06, 8'h20);
		pin(3, 7, 1'b0);
		wr(5'h04, 8'h00);
		cfg(3, 8'h7F, 8'h00);
		pin(3, 7, 1'b0);
		cfg(3, 8'hFF, 8'h00);
		ac <= 2'b01;
		for (int c = 0; c < 8; c++)
		begin
			ac_en <= c > 3 ? 2'b11 : 2'b00;
			wr(5'h06, 8'(c << 6));
			pin(acp[c % 4], 6, c > 3);
		end
		ac_en <= 2'b00;
		wr(5'h06, 8'h00);
		rtc <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			wr(5'h04, 8'(c << 5));
			pin(acp[c], c == 3 ? 0 : 6, c != 0);
		end
		give_verdict();
	end
endmodule // tb
